// *** sgr_pkg.sv ***
// constants shared by the switch global register bank
package sgr_pkg;

   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int IDX_W = 8;
   localparam int REG_W = 8;
   localparam int NUM_IDX = 256;
   localparam int IDX_LSB = 2;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_FAMILY_CODE = 8'h00;
   localparam logic [7:0] IDX_PART_RUN = 8'h01;
   localparam logic [7:0] IDX_CTRL_A = 8'h02;
   localparam logic [7:0] IDX_CTRL_B = 8'h03;
   localparam logic [7:0] IDX_GLOBAL_LO = 8'h02;
   localparam logic [7:0] IDX_GLOBAL_HI = 8'h0f;
   localparam logic [7:0] IDX_PORT1_LO = 8'h10;
   localparam logic [7:0] IDX_PORT1_HI = 8'h1d;
   localparam logic [7:0] IDX_PORT2_LO = 8'h20;
   localparam logic [7:0] IDX_PORT2_HI = 8'h2d;
   localparam logic [7:0] IDX_PORT3_LO = 8'h30;
   localparam logic [7:0] IDX_PORT3_HI = 8'h39;
   localparam logic [7:0] IDX_IND_CTRL_LO = 8'h79;
   localparam logic [7:0] IDX_IND_CTRL_HI = 8'h7a;
   localparam logic [7:0] IDX_IND_DATA_LO = 8'h7b;
   localparam logic [7:0] IDX_IND_DATA_HI = 8'h83;
   localparam logic [7:0] IDX_LINK_STAT = 8'hbb;
   localparam logic [7:0] IDX_LINK_MASK = 8'hbc;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PART_CODE_LSB = 4;
   localparam int REV_LSB = 1;
   localparam int RUN_BIT = 0;
   localparam int ALT_BACKOFF_BIT = 7;
   localparam int LEARNED_FLUSH_BIT = 5;
   localparam int FIXED_FLUSH_BIT = 4;
   localparam int PASS_PAUSE_BIT = 3;
   localparam int FWD_ALL_BIT = 7;
   localparam int TRAILER_TAG_BIT = 6;
   localparam int TX_PAUSE_BIT = 5;
   localparam int NUM_LINK_PORTS = 2;

   // writable bits of the first global control register
   localparam logic [7:0] CTRL_A_WMASK = 8'hbe;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic RUN_RST = 1'b1;
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [7:0] CTRL_B_RST = 8'h34;
   localparam logic [7:0] STORE_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage : sgr_pkg

// *** sgr_reg_if.sv ***
// access strobe and data between bus front end and register core
`timescale 1ns/1ps
`default_nettype none
interface sgr_reg_if;
   logic wr_stb;
   logic [sgr_pkg::IDX_W-1:0] idx;
   logic [sgr_pkg::REG_W-1:0] wdata;
   logic [sgr_pkg::REG_W-1:0] rdata;

   modport front (output wr_stb, output idx, output wdata, input rdata);
   modport core (input wr_stb, input idx, input wdata, output rdata);
endinterface : sgr_reg_if
`default_nettype wire

// *** sgr_avl_front.sv ***
// avalon-mm slave front end with one wait state
`timescale 1ns/1ps
`default_nettype none
module sgr_avl_front
   import sgr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [sgr_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [sgr_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [sgr_pkg::BE_W-1:0] avs_byteenable,
   output logic [sgr_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   sgr_reg_if.front bus
);

   // ---------------------------------------------------------------
   // handshake
   // ---------------------------------------------------------------
   logic wait_r;
   logic wait_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   wire req = avs_read | avs_write;
   wire commit = req & ~wait_r;

   // wait state in first cycle, release for exactly one cycle
   assign wait_nxt = ~(req & wait_r);
   assign rdata_nxt = (avs_read & wait_r) ?
      {{(DATA_W-REG_W){1'b0}}, bus.rdata} : rdata_r;

   // write lands at the edge where the master sees waitrequest low
   assign bus.wr_stb = commit & avs_write & avs_byteenable[0];
   assign bus.idx = avs_address[IDX_LSB +: IDX_W];
   assign bus.wdata = avs_writedata[REG_W-1:0];

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wait_r <= 1'b1;
         rdata_r <= '0;
      end
      else
      begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;

endmodule : sgr_avl_front
`default_nettype wire

// *** sgr_reg_bank.sv ***
// switch global register bank: identification, run control, global controls
`timescale 1ns/1ps
`default_nettype none
module sgr_reg_bank
   import sgr_pkg::*;
#(
   // arbitrary identification values
   parameter logic [7:0] FAMILY_CODE = 8'h5a,
   parameter logic [3:0] PART_CODE = 4'h6,
   parameter logic [2:0] SILICON_REVISION_CODE = 3'h1
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [sgr_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [sgr_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [sgr_pkg::BE_W-1:0] avs_byteenable,
   output logic [sgr_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sniffer_mode,
   input wire logic [sgr_pkg::NUM_LINK_PORTS-1:0] link_change_evt,
   output logic switch_run,
   output logic alt_backoff_en,
   output logic learned_table_flush,
   output logic fixed_table_flush,
   output logic pass_pause_frames,
   output logic forward_all_frames,
   output logic host_trailer_tag_en,
   output logic tx_pause_en,
   output logic [sgr_pkg::NUM_LINK_PORTS-1:0] link_change_pending
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (NUM_LINK_PORTS > REG_W)
   begin : gen_bad_ports
      $error("link port count exceeds register width");
   end

   if (IDX_LSB + IDX_W > ADDR_W)
   begin : gen_bad_addr
      $error("register index does not fit the bus address");
   end

   if (REG_W > DATA_W)
   begin : gen_bad_data
      $error("register width exceeds bus data width");
   end

   if (NUM_IDX != (1 << IDX_W))
   begin : gen_bad_depth
      $error("index count does not match index width");
   end

   if (DATA_W != 8 * BE_W)
   begin : gen_bad_lanes
      $error("byte enables do not cover the data word");
   end

   // ---------------------------------------------------------------
   // bus front end
   // ---------------------------------------------------------------
   sgr_reg_if rif ();

   sgr_avl_front u_front (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .bus(rif.front)
   );

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire [IDX_W-1:0] idx = rif.idx;
   wire [REG_W-1:0] wdata = rif.wdata;
   wire wr = rif.wr_stb;

   wire hit_family = (idx == IDX_FAMILY_CODE);
   wire hit_part_run = (idx == IDX_PART_RUN);
   wire hit_ctrl_a = (idx == IDX_CTRL_A);
   wire hit_ctrl_b = (idx == IDX_CTRL_B);
   wire hit_link_stat = (idx == IDX_LINK_STAT);

   wire wr_part_run = wr & hit_part_run;
   wire wr_ctrl_a = wr & hit_ctrl_a;
   wire wr_ctrl_b = wr & hit_ctrl_b;
   wire wr_link_stat = wr & hit_link_stat;

   // ---------------------------------------------------------------
   // plain read/write storage of the decoded regions
   // ---------------------------------------------------------------
   logic [REG_W-1:0] store_q [NUM_IDX];

   function automatic logic in_range(input int i, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (i >= int'(lo)) && (i <= int'(hi));
   endfunction : in_range

   // control a/b have their own flops; only upper global bytes here
   function automatic logic is_stored(input int i);
      is_stored = (i > int'(IDX_CTRL_B) && in_range(i, IDX_GLOBAL_LO,
                      IDX_GLOBAL_HI))
         || in_range(i, IDX_PORT1_LO, IDX_PORT1_HI)
         || in_range(i, IDX_PORT2_LO, IDX_PORT2_HI)
         || in_range(i, IDX_PORT3_LO, IDX_PORT3_HI)
         || in_range(i, IDX_IND_CTRL_LO, IDX_IND_DATA_HI)
         || (i == int'(IDX_LINK_MASK));
   endfunction : is_stored

   genvar gi;
   for (gi = 0; gi < NUM_IDX; gi++)
   begin : gen_store
      if (is_stored(gi))
      begin : gen_byte
         logic [REG_W-1:0] byte_r;
         wire wr_hit = wr & (idx == IDX_W'(gi));
         always_ff @(posedge ref_clk or negedge reset_n)
         begin
            if (!reset_n)
               byte_r <= STORE_RST;
            else if (wr_hit)
               byte_r <= wdata;
         end
         assign store_q[gi] = byte_r;
      end
      else
      begin : gen_none
         assign store_q[gi] = ZERO_BYTE;
      end
   end

   // ---------------------------------------------------------------
   // run control
   // ---------------------------------------------------------------
   logic run_r;
   wire run_nxt = wr_part_run ? wdata[RUN_BIT] : run_r;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         run_r <= RUN_RST;
      else
         run_r <= run_nxt;
   end

   // ---------------------------------------------------------------
   // global control a
   // ---------------------------------------------------------------
   logic [REG_W-1:0] ctrl_a_r;
   logic [REG_W-1:0] ctrl_a_nxt;

   // read-only reserved bits 6 and 0 never store
   assign ctrl_a_nxt = wr_ctrl_a ? (wdata & CTRL_A_WMASK) : ctrl_a_r;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         ctrl_a_r <= CTRL_A_RST;
      else
         ctrl_a_r <= ctrl_a_nxt;
   end

   // ---------------------------------------------------------------
   // global control b
   // ---------------------------------------------------------------
   logic [REG_W-1:0] ctrl_b_r;
   wire [REG_W-1:0] ctrl_b_nxt = wr_ctrl_b ? wdata : ctrl_b_r;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         ctrl_b_r <= CTRL_B_RST;
      else
         ctrl_b_r <= ctrl_b_nxt;
   end

   // ---------------------------------------------------------------
   // link-change status, write one to clear, event wins
   // ---------------------------------------------------------------
   logic [NUM_LINK_PORTS-1:0] link_stat_r;
   wire [NUM_LINK_PORTS-1:0] link_clr =
      wr_link_stat ? wdata[NUM_LINK_PORTS-1:0] : '0;
   wire [NUM_LINK_PORTS-1:0] link_stat_nxt =
      (link_stat_r & ~link_clr) | link_change_evt;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         link_stat_r <= '0;
      else
         link_stat_r <= link_stat_nxt;
   end

   wire [REG_W-1:0] link_mask = store_q[IDX_LINK_MASK];

   // ---------------------------------------------------------------
   // read data selection
   // ---------------------------------------------------------------
   wire [REG_W-1:0] part_run_rd = {PART_CODE, SILICON_REVISION_CODE,
                                   run_r};
   wire [REG_W-1:0] link_stat_rd = {{(REG_W-NUM_LINK_PORTS){1'b0}},
                                    link_stat_r};

   assign rif.rdata =
      hit_family ? FAMILY_CODE :
      hit_part_run ? part_run_rd :
      hit_ctrl_a ? ctrl_a_r :
      hit_ctrl_b ? ctrl_b_r :
      hit_link_stat ? link_stat_rd :
      store_q[idx];

   // ---------------------------------------------------------------
   // control outputs to the switch datapath
   // ---------------------------------------------------------------
   logic run_o_r;
   logic alt_backoff_r;
   logic learned_flush_r;
   logic fixed_flush_r;
   logic pass_pause_r;
   logic fwd_all_r;
   logic trailer_tag_r;
   logic tx_pause_r;
   logic [NUM_LINK_PORTS-1:0] pending_r;

   wire fwd_all_nxt = ctrl_b_nxt[FWD_ALL_BIT] & sniffer_mode;
   wire [NUM_LINK_PORTS-1:0] pending_nxt =
      link_stat_nxt & link_mask[NUM_LINK_PORTS-1:0];

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         run_o_r <= RUN_RST;
      else
         run_o_r <= run_nxt;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         alt_backoff_r <= CTRL_A_RST[ALT_BACKOFF_BIT];
      else
         alt_backoff_r <= ctrl_a_nxt[ALT_BACKOFF_BIT];
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         learned_flush_r <= CTRL_A_RST[LEARNED_FLUSH_BIT];
      else
         learned_flush_r <= ctrl_a_nxt[LEARNED_FLUSH_BIT];
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         fixed_flush_r <= CTRL_A_RST[FIXED_FLUSH_BIT];
      else
         fixed_flush_r <= ctrl_a_nxt[FIXED_FLUSH_BIT];
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         pass_pause_r <= CTRL_A_RST[PASS_PAUSE_BIT];
      else
         pass_pause_r <= ctrl_a_nxt[PASS_PAUSE_BIT];
   end

   // ---------------------------------------------------------------
   // second control outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         fwd_all_r <= CTRL_B_RST[FWD_ALL_BIT];
      else
         fwd_all_r <= fwd_all_nxt;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         trailer_tag_r <= CTRL_B_RST[TRAILER_TAG_BIT];
      else
         trailer_tag_r <= ctrl_b_nxt[TRAILER_TAG_BIT];
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         tx_pause_r <= CTRL_B_RST[TX_PAUSE_BIT];
      else
         tx_pause_r <= ctrl_b_nxt[TX_PAUSE_BIT];
   end

   // ---------------------------------------------------------------
   // link-change output
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         pending_r <= '0;
      else
         pending_r <= pending_nxt;
   end

   assign switch_run = run_o_r;
   assign alt_backoff_en = alt_backoff_r;
   assign learned_table_flush = learned_flush_r;
   assign fixed_table_flush = fixed_flush_r;
   assign pass_pause_frames = pass_pause_r;
   assign forward_all_frames = fwd_all_r;
   assign host_trailer_tag_en = trailer_tag_r;
   assign tx_pause_en = tx_pause_r;
   assign link_change_pending = pending_r;

endmodule : sgr_reg_bank
`default_nettype wire

// *** sgr_monitor.sv ***
// assertion checker bound to the switch global register bank
`timescale 1ns/1ps
`default_nettype none
module sgr_monitor
   import sgr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [sgr_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [sgr_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [sgr_pkg::BE_W-1:0] avs_byteenable,
   input wire logic [sgr_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic sniffer_mode,
   input wire logic switch_run,
   input wire logic alt_backoff_en,
   input wire logic learned_table_flush,
   input wire logic fixed_table_flush,
   input wire logic pass_pause_frames,
   input wire logic forward_all_frames,
   input wire logic host_trailer_tag_en,
   input wire logic tx_pause_en
);
   wire cmt;
   wire rdone;
   wire [7:0] idx;
   wire [7:0] wd;
   wire [6:0] outs;
   assign cmt = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign rdone = avs_read & ~avs_waitrequest;
   assign idx = avs_address[9:2];
   assign wd = avs_writedata[7:0];
   assign outs = {switch_run, alt_backoff_en, learned_table_flush,
      fixed_table_flush, pass_pause_frames, host_trailer_tag_en, tx_pause_en};

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // ---------------------------------------------------------------
   // bus timing
   // ---------------------------------------------------------------
   chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest not low one cycle after request");
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_rd_upper: assert property (rdone |-> avs_readdata[31:8] == 24'h0)
      else $error("read data upper lanes not zero");

   // ---------------------------------------------------------------
   // register outputs
   // ---------------------------------------------------------------
   chk_run_write: assert property (cmt && idx == 8'h01 |=> switch_run == $past(wd[0]))
      else $error("run control does not follow write");
   chk_run_read: assert property (rdone && idx == 8'h01 |-> avs_readdata[0] == switch_run)
      else $error("run control read back differs from output");
   chk_ctrl_a: assert property (cmt && idx == 8'h02 |=> {alt_backoff_en, learned_table_flush, fixed_table_flush, pass_pause_frames} == $past({wd[7], wd[5:3]}))
      else $error("first control outputs do not follow write");
   chk_ctrl_b: assert property (cmt && idx == 8'h03 |=> {host_trailer_tag_en, tx_pause_en} == $past(wd[6:5]))
      else $error("second control outputs do not follow write");
   chk_fwd_gate: assert property (forward_all_frames |-> $past(sniffer_mode))
      else $error("forward all frames without sniffer mode");
   chk_hold_idle: assert property (!(cmt && idx inside {[8'h01:8'h03]}) |=> $stable(outs))
      else $error("control outputs changed without a write");

   cov_write_a: cover property (cmt && idx == 8'h02);
   cov_read_run: cover property (rdone && idx == 8'h01);
   cov_fwd_all: cover property (forward_all_frames);
endmodule : sgr_monitor

bind sgr_reg_bank sgr_monitor u_sgr_monitor (.ref_clk, .reset_n,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_readdata, .avs_waitrequest, .sniffer_mode, .switch_run,
   .alt_backoff_en, .learned_table_flush, .fixed_table_flush,
   .pass_pause_frames, .forward_all_frames, .host_trailer_tag_en,
   .tx_pause_en);
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the switch global register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sgr_pkg::*;
   // arbitrary identification values
   localparam logic [7:0] FAM = 8'hc3;
   localparam logic [3:0] PRT = 4'h9;
   localparam logic [2:0] REV = 3'h5;
   localparam logic [7:0] EDGES [19] = '{8'h00, 8'h01, 8'h0f, 8'h10, 8'h1d,
      8'h1e, 8'h20, 8'h2d, 8'h2f, 8'h30, 8'h39, 8'h3a, 8'h79, 8'h83, 8'h84,
      8'hbb, 8'hbc, 8'hbd, 8'hff};
   logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic sniffer_mode, switch_run, alt_backoff_en, learned_table_flush;
   logic fixed_table_flush, pass_pause_frames, forward_all_frames;
   logic host_trailer_tag_en, tx_pause_en;
   logic [ADDR_W-1:0] avs_address;
   logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
   logic [BE_W-1:0] avs_byteenable;
   logic [1:0] link_change_evt, link_change_pending;
   logic [7:0] mdl [256];
   logic [7:0] i, d;
   int miscompares = 0;
   int tests_run = 0;

   sgr_reg_bank #(.FAMILY_CODE(FAM), .PART_CODE(PRT),
      .SILICON_REVISION_CODE(REV)) u_sgr_reg_bank (.ref_clk, .reset_n,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .sniffer_mode, .link_change_evt,
      .switch_run, .alt_backoff_en, .learned_table_flush, .fixed_table_flush,
      .pass_pause_frames, .forward_all_frames, .host_trailer_tag_en,
      .tx_pause_en, .link_change_pending);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] wmask(input logic [7:0] x);
      if (x == 8'h01)
         return 8'h01;
      if (x == 8'h02)
         return 8'hbe;
      if (x inside {[8'h03:8'h0f], [8'h10:8'h1d], [8'h20:8'h2d],
         [8'h30:8'h39], [8'h79:8'h83], 8'hbc})
         return 8'hff;
      return 8'h00;
   endfunction : wmask

   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // one avalon transfer; holds the request until waitrequest is low
   task automatic bus(input logic wr, input logic [7:0] x,
      input logic [7:0] v, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= {x, 2'b00};
      avs_writedata <= {24'($urandom), v};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      // only the watchdog ends a wait that never gets an answer
      do
         @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (wr && be[0])
         mdl[x] = (mdl[x] & ~wmask(x)) | (v & wmask(x));
   endtask : bus

   task automatic rchk(input logic [7:0] x);
      bus(1'b0, x, 8'h00, 4'hf);
      check("readdata", rd, {24'h0, mdl[x]});
   endtask : rchk

   task automatic chk_outs();
      check("ctrl_outs", 32'({switch_run, alt_backoff_en, learned_table_flush,
         fixed_table_flush, pass_pause_frames}),
         32'({mdl[1][0], mdl[2][7], mdl[2][5:3]}));
      check("ctrl_b_outs", 32'({host_trailer_tag_en, tx_pause_en,
         forward_all_frames}),
         32'({mdl[3][6:5], mdl[3][7] & sniffer_mode}));
   endtask : chk_outs

   task automatic reset_run();
      reset_n <= 1'b0;
      sniffer_mode <= 1'b0;
      foreach (mdl[k])
         mdl[k] = 8'h00;
      mdl[0] = FAM;
      mdl[1] = {PRT, REV, 1'b1};
      mdl[3] = 8'h34;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      chk_outs();
      for (int k = 0; k < 4; k++)
         rchk(8'(k));
      $display("test reset values done");
   endtask : reset_run

   // ---------------------------------------------------------------
   // clock, watchdog, main sequence
   // ---------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // about 2000 cycles expected; 50000 leaves a wide margin
   initial
   begin
      #500000;
      miscompares++;
      summarize();
   end

   initial
   begin
      reset_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      avs_byteenable = '0;
      sniffer_mode = 1'b0;
      link_change_evt = 2'b00;
      void'($urandom(45));
      reset_run();
      for (int k = 0; k < 19; k++)
      begin
         bus(1'b1, EDGES[k], 8'hff, 4'h1);
         rchk(EDGES[k]);
      end
      bus(1'b1, 8'h0f, 8'h00, 4'he);
      rchk(8'h0f);
      $display("test map boundaries done");
      for (int k = 0; k < 300; k++)
      begin
         i = ($urandom_range(1) != 0) ? 8'($urandom_range(3)) : 8'($urandom);
         d = 8'($urandom);
         if (i == 8'h02)
            d = d & 8'hf9;
         sniffer_mode <= 1'($urandom);
         bus(1'b1, i, d, 4'($urandom));
         rchk(i);
         chk_outs();
      end
      $display("test random access done");
      @(posedge ref_clk);
      link_change_evt <= 2'b11;
      @(posedge ref_clk);
      link_change_evt <= 2'b00;
      mdl[8'hbb] = 8'h03;
      // mask hides the first port, so only the second may pend
      bus(1'b1, 8'hbc, 8'h02, 4'h1);
      rchk(8'hbb);
      check("pending", 32'(link_change_pending), 32'h2);
      bus(1'b1, 8'hbb, 8'h03, 4'h1);
      mdl[8'hbb] = 8'h00;
      rchk(8'hbb);
      check("pending", 32'(link_change_pending), 32'h0);
      $display("test link change done");
      reset_run();
      summarize();
   end
endmodule : tb
`default_nettype wire
